// File: inc/psc_defs.svh
// Offsets, field positions, reset values and sizes for the pin sharing control
`ifndef PSC_DEFS_SVH
`define PSC_DEFS_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define PSC_NPIN 14
`define PSC_NALT 4
`define PSC_NPA 6
`define PSC_NPB 8
`define PSC_AW 4
`define PSC_DW 8

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PSC_OFS_DATA_A 4'h0
`define PSC_OFS_DIR_A 4'h1
`define PSC_OFS_PULL_A 4'h2
`define PSC_OFS_SLEW_A 4'h3
`define PSC_OFS_DRV_A 4'h4
`define PSC_OFS_DATA_B 4'h5
`define PSC_OFS_DIR_B 4'h6
`define PSC_OFS_PULL_B 4'h7
`define PSC_OFS_SLEW_B 4'h8
`define PSC_OFS_DRV_B 4'h9
`define PSC_OFS_OPT2 4'hA
`define PSC_OFS_OWN_SEL 4'hB
`define PSC_OFS_OWN_STAT 4'hC

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define PSC_OPT2_RELOC_BIT 0
`define PSC_RST_BYTE 8'h00
`define PSC_RST_RELOC 1'b0

// ----------------------------------------------------------------
// Fixed sharing positions (pin index, alternative slot index)
// ----------------------------------------------------------------
`define PSC_TW_SLOT 1
`define PSC_ADC_SLOT 2
`define PSC_CMP_SLOT 3
`define PSC_PIN_SDA_DEF 2
`define PSC_PIN_SCL_DEF 3
`define PSC_PIN_SDA_ALT 12
`define PSC_PIN_SCL_ALT 13
`define PSC_ANA_SHARE_MASK 14'h0003

`endif

// File: inc/psc_pkg.sv
// Types shared by the pin sharing control design
package psc_pkg;

   // One function's request on a pin
   typedef struct packed {
      logic en;
      logic oe;
      logic dout;
      logic ana;
   } psc_fn_t;

   // Conditioned drive for one pad
   typedef struct packed {
      logic oe;
      logic dout;
      logic slew;
      logic hdrv;
      logic pull;
   } psc_pad_t;

   typedef enum logic [2:0] {PSC_OWN_PORT, PSC_OWN_ALT1, PSC_OWN_ALT2, PSC_OWN_ALT3,
      PSC_OWN_ALT4} psc_owner_t;

endpackage

// File: hdl/psc_pin_cell.sv
// Output conditioning for one shared pin
`timescale 1ns/1ps
module psc_pin_cell (
   input wire logic clk_i, // Bus clock
   input wire logic rst_n_i, // Synchronous reset, active low
   input wire logic oe_i, // Owner drives the pin
   input wire logic dout_i, // Owner's output level
   input wire logic ana_i, // Owner is an analog function
   input wire logic slew_i, // Slew limit enable bit
   input wire logic hdrv_i, // High drive select bit
   input wire logic pull_i, // Pullup enable bit
   output psc_pkg::psc_pad_t pad_o // Registered pad controls
);

   psc_pkg::psc_pad_t pad_reg;
   psc_pkg::psc_pad_t pad_next;

   // ----------------------------------------------------------------
   // Conditioning
   // ----------------------------------------------------------------
   always_comb begin
      pad_next.oe = oe_i && !ana_i;
      pad_next.dout = oe_i && !ana_i && dout_i;
      pad_next.slew = pad_next.oe && slew_i;
      pad_next.hdrv = pad_next.oe && hdrv_i;
      pad_next.pull = pull_i && !oe_i && !ana_i;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pad_reg <= '0;
      end else begin
         pad_reg <= pad_next;
      end
   end

   assign pad_o = pad_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_slew_out;
      @(posedge clk_i) disable iff (!rst_n_i)
      (oe_i && !ana_i && slew_i) |=> pad_o.slew && pad_o.oe;
   endproperty
   a_slew_out: assert property (p_slew_out) else $error("slew limit not applied");

   property p_slew_in;
      @(posedge clk_i) disable iff (!rst_n_i)
      !pad_o.oe |-> !pad_o.slew;
   endproperty
   a_slew_in: assert property (p_slew_in) else $error("slew active on input");

   property p_hdrv;
      @(posedge clk_i) disable iff (!rst_n_i)
      (oe_i && !ana_i) |=> (pad_o.hdrv == $past(hdrv_i));
   endproperty
   a_hdrv: assert property (p_hdrv) else $error("drive select not followed");

   property p_pull;
      @(posedge clk_i) disable iff (!rst_n_i)
      (oe_i || ana_i) |=> !pad_o.pull;
   endproperty
   a_pull: assert property (p_pull) else $error("pullup on while driven");

endmodule // psc_pin_cell

// File: hdl/psc_top.sv
// Pin sharing control: registers, priority arbitration and pad conditioning
// ----------------------------------------------------------------
// Overview of operation
// - Per-pin slew limit bit limits output edges
// - Slew bit ignored while pin is input
// - Per-pin bit selects high output drive
// - Highest priority enabled module owns pin
// - Two-wire pins relocatable; reset on A2/A3
// - Comparator and converter share pins 0 and 1 together
// - Pullup off whenever pin drives output
// ----------------------------------------------------------------
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "psc_defs.svh"
module psc_top (
   input wire logic clk_i, // Bus clock, 100 MHz
   input wire logic rst_n_i, // Synchronous reset, active low
   input wire logic [`PSC_AW-1:0] addr_i, // Register address
   input wire logic [`PSC_DW-1:0] wdata_i, // Write data
   input wire logic wr_i, // Write strobe
   input wire logic rd_i, // Read strobe
   output logic [`PSC_DW-1:0] rdata_o, // Read data, cycle after rd_i
   input psc_pkg::psc_fn_t [`PSC_NPIN-1:0][`PSC_NALT-1:0] alt_fn_i, // Module requests
   input psc_pkg::psc_fn_t tw_sda_i, // Two-wire data request
   input psc_pkg::psc_fn_t tw_scl_i, // Two-wire clock request
   input wire logic [`PSC_NPIN-1:0] pad_in_i, // Pad input levels
   output logic [`PSC_NPIN-1:0] pin_in_o, // Synchronised pin levels
   output logic [`PSC_NPIN-1:0][`PSC_NALT:0] grant_o, // Pin access per slot
   output psc_pkg::psc_pad_t [`PSC_NPIN-1:0] pad_o // Pad drive controls
);

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [`PSC_NPIN-1:0] data_reg, data_next;
   logic [`PSC_NPIN-1:0] dir_reg, dir_next;
   logic [`PSC_NPIN-1:0] pull_reg, pull_next;
   logic [`PSC_NPIN-1:0] slew_reg, slew_next;
   logic [`PSC_NPIN-1:0] drv_reg, drv_next;
   logic reloc_reg, reloc_next;
   logic [3:0] own_sel_reg, own_sel_next;
   logic [`PSC_DW-1:0] rdata_reg, rdata_next;
   logic [`PSC_NPIN-1:0] sync1_reg, sync2_reg;

   logic [`PSC_DW-1:0] own_stat;
   psc_pkg::psc_fn_t [`PSC_NPIN-1:0][`PSC_NALT-1:0] eff_fn;
   psc_pkg::psc_owner_t [`PSC_NPIN-1:0] owner;
   logic [`PSC_NPIN-1:0] sel_oe, sel_dout, sel_ana, share_hit;
   // Analog sharing is wired per pin, not chosen by software
   logic [`PSC_NPIN-1:0] ana_share;

   assign ana_share = `PSC_ANA_SHARE_MASK;

   // ----------------------------------------------------------------
   // Pad input synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= pad_in_i;
         sync2_reg <= sync1_reg;
      end
   end

   assign pin_in_o = sync2_reg;

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   always_comb begin
      data_next = data_reg;
      dir_next = dir_reg;
      pull_next = pull_reg;
      slew_next = slew_reg;
      drv_next = drv_reg;
      reloc_next = reloc_reg;
      own_sel_next = own_sel_reg;
      if (wr_i) begin
         unique case (addr_i)
            `PSC_OFS_DATA_A: data_next[`PSC_NPA-1:0] = wdata_i[`PSC_NPA-1:0];
            `PSC_OFS_DIR_A: dir_next[`PSC_NPA-1:0] = wdata_i[`PSC_NPA-1:0];
            `PSC_OFS_PULL_A: pull_next[`PSC_NPA-1:0] = wdata_i[`PSC_NPA-1:0];
            `PSC_OFS_SLEW_A: slew_next[`PSC_NPA-1:0] = wdata_i[`PSC_NPA-1:0];
            `PSC_OFS_DRV_A: drv_next[`PSC_NPA-1:0] = wdata_i[`PSC_NPA-1:0];
            `PSC_OFS_DATA_B: data_next[`PSC_NPIN-1:`PSC_NPA] = wdata_i;
            `PSC_OFS_DIR_B: dir_next[`PSC_NPIN-1:`PSC_NPA] = wdata_i;
            `PSC_OFS_PULL_B: pull_next[`PSC_NPIN-1:`PSC_NPA] = wdata_i;
            `PSC_OFS_SLEW_B: slew_next[`PSC_NPIN-1:`PSC_NPA] = wdata_i;
            `PSC_OFS_DRV_B: drv_next[`PSC_NPIN-1:`PSC_NPA] = wdata_i;
            `PSC_OFS_OPT2: reloc_next = wdata_i[`PSC_OPT2_RELOC_BIT];
            `PSC_OFS_OWN_SEL: own_sel_next = wdata_i[3:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         data_reg <= '0;
         dir_reg <= '0;
         pull_reg <= '0;
         slew_reg <= '0;
         drv_reg <= '0;
         reloc_reg <= `PSC_RST_RELOC;
         own_sel_reg <= 4'h0;
      end else begin
         data_reg <= data_next;
         dir_reg <= dir_next;
         pull_reg <= pull_next;
         slew_reg <= slew_next;
         drv_reg <= drv_next;
         reloc_reg <= reloc_next;
         own_sel_reg <= own_sel_next;
      end
   end

   // ----------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------
   // Data reads show the pad level, so a driven pin reads back what it shows
   always_comb begin
      rdata_next = `PSC_RST_BYTE;
      if (rd_i) begin
         unique case (addr_i)
            `PSC_OFS_DATA_A: rdata_next = {2'h0, sync2_reg[`PSC_NPA-1:0]};
            `PSC_OFS_DIR_A: rdata_next = {2'h0, dir_reg[`PSC_NPA-1:0]};
            `PSC_OFS_PULL_A: rdata_next = {2'h0, pull_reg[`PSC_NPA-1:0]};
            `PSC_OFS_SLEW_A: rdata_next = {2'h0, slew_reg[`PSC_NPA-1:0]};
            `PSC_OFS_DRV_A: rdata_next = {2'h0, drv_reg[`PSC_NPA-1:0]};
            `PSC_OFS_DATA_B: rdata_next = sync2_reg[`PSC_NPIN-1:`PSC_NPA];
            `PSC_OFS_DIR_B: rdata_next = dir_reg[`PSC_NPIN-1:`PSC_NPA];
            `PSC_OFS_PULL_B: rdata_next = pull_reg[`PSC_NPIN-1:`PSC_NPA];
            `PSC_OFS_SLEW_B: rdata_next = slew_reg[`PSC_NPIN-1:`PSC_NPA];
            `PSC_OFS_DRV_B: rdata_next = drv_reg[`PSC_NPIN-1:`PSC_NPA];
            `PSC_OFS_OPT2: rdata_next = {7'h00, reloc_reg};
            `PSC_OFS_OWN_SEL: rdata_next = {4'h0, own_sel_reg};
            `PSC_OFS_OWN_STAT: rdata_next = own_stat;
            default: rdata_next = `PSC_RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rdata_reg <= `PSC_RST_BYTE;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign rdata_o = rdata_reg;

   // Owner status of the selected pin; out-of-range selects read zero
   always_comb begin
      own_stat = `PSC_RST_BYTE;
      if (own_sel_reg < 4'(`PSC_NPIN)) begin
         own_stat = {3'h0, pad_o[own_sel_reg].pull, share_hit[own_sel_reg],
            owner[own_sel_reg]};
      end
   end

   // ----------------------------------------------------------------
   // Two-wire routing
   // ----------------------------------------------------------------
   // Unselected location sees its two-wire slot as disabled
   always_comb begin
      eff_fn = alt_fn_i;
      eff_fn[`PSC_PIN_SDA_DEF][`PSC_TW_SLOT] = reloc_reg ? '0 : tw_sda_i;
      eff_fn[`PSC_PIN_SCL_DEF][`PSC_TW_SLOT] = reloc_reg ? '0 : tw_scl_i;
      eff_fn[`PSC_PIN_SDA_ALT][`PSC_TW_SLOT] = reloc_reg ? tw_sda_i : '0;
      eff_fn[`PSC_PIN_SCL_ALT][`PSC_TW_SLOT] = reloc_reg ? tw_scl_i : '0;
   end

   // ----------------------------------------------------------------
   // Per-pin arbitration and conditioning
   // ----------------------------------------------------------------
   for (genvar p = 0; p < `PSC_NPIN; p++) begin : g_pin
      always_comb begin
         owner[p] = psc_pkg::PSC_OWN_PORT;
         sel_oe[p] = dir_reg[p];
         sel_dout[p] = data_reg[p];
         sel_ana[p] = 1'b0;
         for (int s = 0; s < `PSC_NALT; s++) begin
            if (eff_fn[p][s].en) begin
               owner[p] = psc_pkg::psc_owner_t'(3'(s + 1));
               sel_oe[p] = eff_fn[p][s].oe;
               sel_dout[p] = eff_fn[p][s].dout;
               sel_ana[p] = eff_fn[p][s].ana;
            end
         end
      end

      assign share_hit[p] = ana_share[p] && eff_fn[p][`PSC_CMP_SLOT].en &&
         eff_fn[p][`PSC_ADC_SLOT].en;

      always_comb begin
         grant_o[p] = '0;
         grant_o[p][owner[p]] = 1'b1;
         grant_o[p][`PSC_ADC_SLOT + 1] = grant_o[p][`PSC_ADC_SLOT + 1] || share_hit[p];
      end

      psc_pin_cell u_cell (
         .clk_i(clk_i),
         .rst_n_i(rst_n_i),
         .oe_i(sel_oe[p]),
         .dout_i(sel_dout[p]),
         .ana_i(sel_ana[p]),
         .slew_i(slew_reg[p]),
         .hdrv_i(drv_reg[p]),
         .pull_i(pull_reg[p]),
         .pad_o(pad_o[p])
      );

      property p_prio;
         @(posedge clk_i) disable iff (!rst_n_i)
         eff_fn[p][`PSC_NALT-1].en && !eff_fn[p][`PSC_NALT-1].ana |=>
            pad_o[p].oe == $past(eff_fn[p][`PSC_NALT-1].oe);
      endproperty
      a_prio: assert property (p_prio) else $error("top slot not in control");

      property p_port;
         @(posedge clk_i) disable iff (!rst_n_i)
         (eff_fn[p] == '0) |=> pad_o[p].oe == $past(dir_reg[p]) &&
            pad_o[p].dout == ($past(dir_reg[p]) && $past(data_reg[p]));
      endproperty
      a_port: assert property (p_port) else $error("port logic lost idle pin");

      property p_share;
         @(posedge clk_i) disable iff (!rst_n_i)
         share_hit[p] |-> grant_o[p][`PSC_CMP_SLOT + 1] && grant_o[p][`PSC_ADC_SLOT + 1];
      endproperty
      a_share: assert property (p_share) else $error("analog pair not both granted");

      property p_grant_single;
         @(posedge clk_i) disable iff (!rst_n_i)
         !share_hit[p] |-> $onehot(grant_o[p]);
      endproperty
      a_grant_single: assert property (p_grant_single) else $error("pin granted twice");

      property p_top_owner;
         @(posedge clk_i) disable iff (!rst_n_i)
         eff_fn[p][`PSC_NALT-1].en |-> owner[p] == psc_pkg::PSC_OWN_ALT4;
      endproperty
      a_top_owner: assert property (p_top_owner) else $error("top slot lost the pin");

      property p_port_pull;
         @(posedge clk_i) disable iff (!rst_n_i)
         owner[p] == psc_pkg::PSC_OWN_PORT && dir_reg[p] |=> !pad_o[p].pull;
      endproperty
      a_port_pull: assert property (p_port_pull) else $error("pullup on port output");

      property p_in_plain;
         @(posedge clk_i) disable iff (!rst_n_i)
         !sel_oe[p] |=> !pad_o[p].slew && !pad_o[p].hdrv;
      endproperty
      a_in_plain: assert property (p_in_plain) else $error("output controls on input");

      property p_ana_quiet;
         @(posedge clk_i) disable iff (!rst_n_i)
         sel_ana[p] |=> !pad_o[p].oe && !pad_o[p].pull;
      endproperty
      a_ana_quiet: assert property (p_ana_quiet) else $error("analog pin driven");
   end

   // ----------------------------------------------------------------
   // Relocation checks
   // ----------------------------------------------------------------
   sequence s_reloc_wr;
      wr_i && addr_i == `PSC_OFS_OPT2 && wdata_i[`PSC_OPT2_RELOC_BIT];
   endsequence

   sequence s_reloc_used;
      // Higher slots on the new pin may still win it
      reloc_reg ##0 (!tw_sda_i.en || eff_fn[`PSC_PIN_SDA_ALT][`PSC_NALT-1].en ||
         eff_fn[`PSC_PIN_SDA_ALT][`PSC_TW_SLOT + 1].en ||
         grant_o[`PSC_PIN_SDA_ALT][`PSC_TW_SLOT + 1]);
   endsequence

   property p_reloc;
      @(posedge clk_i) disable iff (!rst_n_i)
      s_reloc_wr |=> s_reloc_used;
   endproperty
   a_reloc: assert property (p_reloc) else $error("relocation not applied");

   property p_reloc_def;
      @(posedge clk_i) disable iff (!rst_n_i)
      !reloc_reg && tw_scl_i.en && !eff_fn[`PSC_PIN_SCL_DEF][`PSC_NALT-1].en &&
         !eff_fn[`PSC_PIN_SCL_DEF][`PSC_TW_SLOT + 1].en
         |-> grant_o[`PSC_PIN_SCL_DEF][`PSC_TW_SLOT + 1] &&
            !grant_o[`PSC_PIN_SCL_ALT][`PSC_TW_SLOT + 1];
   endproperty
   a_reloc_def: assert property (p_reloc_def) else $error("default location wrong");

   property p_reloc_vacate;
      @(posedge clk_i) disable iff (!rst_n_i)
      reloc_reg |-> !grant_o[`PSC_PIN_SDA_DEF][`PSC_TW_SLOT + 1] &&
         !grant_o[`PSC_PIN_SCL_DEF][`PSC_TW_SLOT + 1];
   endproperty
   a_reloc_vacate: assert property (p_reloc_vacate) else $error("two-wire left behind");

   property p_def_vacate;
      @(posedge clk_i) disable iff (!rst_n_i)
      !reloc_reg |-> !grant_o[`PSC_PIN_SDA_ALT][`PSC_TW_SLOT + 1] &&
         !grant_o[`PSC_PIN_SCL_ALT][`PSC_TW_SLOT + 1];
   endproperty
   a_def_vacate: assert property (p_def_vacate) else $error("two-wire on spare pins");

endmodule // psc_top

// File: sim/psc_periph_model.sv
// Model of the peripherals and board levels around the pin sharing control
`timescale 1ns/1ps
`include "psc_defs.svh"
module psc_periph_model (
   input wire logic clk_i, // Bus clock
   input wire logic rst_n_i, // Synchronous reset, active low
   input wire logic step_i, // Draw a new set of requests
   output psc_pkg::psc_fn_t [`PSC_NPIN-1:0][`PSC_NALT-1:0] alt_fn_o, // Module requests
   output psc_pkg::psc_fn_t tw_sda_o, // Two-wire data request
   output psc_pkg::psc_fn_t tw_scl_o, // Two-wire clock request
   output logic [`PSC_NPIN-1:0] pad_in_o // Board levels
);
   logic quiet_reg;

   // Sparse enables so that the port logic still owns some pins
   function automatic psc_pkg::psc_fn_t rnd_fn();
      psc_pkg::psc_fn_t f;
      f.en = ($urandom % 3) == 0;
      f.oe = 1'($urandom);
      f.dout = 1'($urandom);
      f.ana = ($urandom % 4) == 0;
      return f;
   endfunction

   always @(posedge clk_i) begin
      if (!rst_n_i || step_i) begin
         alt_fn_o <= '0;
         tw_sda_o <= '0;
         tw_scl_o <= '0;
         quiet_reg <= rst_n_i;
         if (!rst_n_i) begin
            pad_in_o <= '0;
         end
      end else if (quiet_reg) begin
         quiet_reg <= 1'b0;
         for (int p = 0; p < `PSC_NPIN; p++) begin
            for (int s = 0; s < `PSC_NALT; s++) begin
               alt_fn_o[p][s] <= rnd_fn();
            end
         end
         tw_sda_o <= rnd_fn();
         tw_scl_o <= rnd_fn();
         pad_in_o <= `PSC_NPIN'($urandom);
      end
   end
endmodule // psc_periph_model

// File: sim/testbench.sv
// Self-checking bench for the pin sharing control
`timescale 1ns/1ps
`include "psc_defs.svh"
module testbench;
   logic clk_i;
   logic rst_n_i;
   logic [`PSC_AW-1:0] addr_i;
   logic [`PSC_DW-1:0] wdata_i;
   logic wr_i;
   logic rd_i;
   logic step;
   logic [`PSC_DW-1:0] rdata_o;
   psc_pkg::psc_fn_t [`PSC_NPIN-1:0][`PSC_NALT-1:0] alt_fn;
   psc_pkg::psc_fn_t tw_sda;
   psc_pkg::psc_fn_t tw_scl;
   logic [`PSC_NPIN-1:0] pad_in;
   logic [`PSC_NPIN-1:0] pin_in_o;
   logic [`PSC_NPIN-1:0][`PSC_NALT:0] grant_o;
   psc_pkg::psc_pad_t [`PSC_NPIN-1:0] pad_o;
   logic [7:0] regs [0:15];
   logic [`PSC_NPIN-1:0] share_m = `PSC_ANA_SHARE_MASK;
   int err_count = 0;
   int total_checks = 0;

   psc_top i_psc_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .alt_fn_i(alt_fn), .tw_sda_i(tw_sda),
      .tw_scl_i(tw_scl), .pad_in_i(pad_in), .pin_in_o(pin_in_o), .grant_o(grant_o),
      .pad_o(pad_o));
   psc_periph_model i_psc_periph_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .step_i(step),
      .alt_fn_o(alt_fn), .tw_sda_o(tw_sda), .tw_scl_o(tw_scl), .pad_in_o(pad_in));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
         err_count++;
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      regs[a] = d;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      chk(n, e, rdata_o);
   endtask

   // Register bit of a pin; port B block sits five offsets above port A
   function automatic logic rbit(int ofs, int p);
      return (p < `PSC_NPA) ? regs[ofs][p] : regs[ofs + 5][p - `PSC_NPA];
   endfunction

   // Slot 1 of the selected pin pair carries the two-wire requests
   function automatic psc_pkg::psc_fn_t eff(int p, int s);
      logic rl;
      rl = regs[`PSC_OFS_OPT2][`PSC_OPT2_RELOC_BIT];
      if (s == `PSC_TW_SLOT && p == (rl ? `PSC_PIN_SDA_ALT : `PSC_PIN_SDA_DEF)) return tw_sda;
      if (s == `PSC_TW_SLOT && p == (rl ? `PSC_PIN_SCL_ALT : `PSC_PIN_SCL_DEF)) return tw_scl;
      // The unselected pair sees its two-wire slot idle
      if (s == `PSC_TW_SLOT && (p == `PSC_PIN_SDA_DEF || p == `PSC_PIN_SCL_DEF ||
         p == `PSC_PIN_SDA_ALT || p == `PSC_PIN_SCL_ALT)) return '0;
      return alt_fn[p][s];
   endfunction

   function automatic int winner(int p);
      psc_pkg::psc_fn_t f;
      int w;
      w = -1;
      for (int s = 0; s < `PSC_NALT; s++) begin
         f = eff(p, s);
         if (f.en) w = s;
      end
      return w;
   endfunction

   function automatic logic [7:0] exp_grant(int p);
      logic [7:0] g;
      psc_pkg::psc_fn_t fa;
      psc_pkg::psc_fn_t fc;
      fa = eff(p, `PSC_ADC_SLOT);
      fc = eff(p, `PSC_CMP_SLOT);
      g = 8'h01 << (winner(p) + 1);
      if (share_m[p] && fa.en && fc.en) begin
         g[`PSC_ADC_SLOT + 1] = 1'b1;
      end
      return g;
   endfunction

   // Dout only matters while the pad is driven
   function automatic logic [7:0] exp_pad(int p);
      logic oe;
      logic dout;
      logic ana;
      int w;
      psc_pkg::psc_fn_t f;
      w = winner(p);
      f = '0;
      if (w >= 0) f = eff(p, w);
      oe = (w < 0) ? rbit(`PSC_OFS_DIR_A, p) : f.oe & ~f.ana;
      dout = (w < 0) ? rbit(`PSC_OFS_DATA_A, p) : f.dout;
      ana = f.ana;
      return {3'h0, oe, oe & dout, oe & rbit(`PSC_OFS_SLEW_A, p),
         oe & rbit(`PSC_OFS_DRV_A, p), ~oe & ~ana & rbit(`PSC_OFS_PULL_A, p)};
   endfunction

   function automatic logic [7:0] seen_pad(psc_pkg::psc_pad_t x);
      return {3'h0, x.oe, x.oe & x.dout, x.slew, x.hdrv, x.pull};
   endfunction

   // Owner status byte: pullup, analog sharing, winning owner
   function automatic logic [7:0] exp_stat(int p);
      logic [7:0] g;
      logic [7:0] x;
      if (p >= `PSC_NPIN) return 8'h00;
      g = exp_grant(p);
      x = exp_pad(p);
      return {3'h0, x[0], g[`PSC_CMP_SLOT + 1] & g[`PSC_ADC_SLOT + 1], 3'(winner(p) + 1)};
   endfunction

   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      logic [7:0] v;
      rst_n_i = 1'b0;
      addr_i = '0;
      wdata_i = '0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      step = 1'b0;
      void'($urandom(32'h73A35E13));
      for (int k = 0; k < 16; k++) regs[k] = 8'h00;
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      // ----------------------------------------------------------------
      // Reset state, unmapped addresses included
      // ----------------------------------------------------------------
      for (int a = 0; a < 16; a++) rd(4'(a), 8'h00, "reset read");
      for (int p = 0; p < `PSC_NPIN; p++) begin
         chk("reset pad", 8'h00, seen_pad(pad_o[p]));
         chk("reset grant", 8'h01, 8'(grant_o[p]));
      end
      $display("test reset done");
      // ----------------------------------------------------------------
      // Random requests and register values, all-ones and all-zeros register values first
      // ----------------------------------------------------------------
      for (int i = 0; i < 40; i++) begin
         for (int a = 0; a < 10; a++) begin
            v = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
            wr(4'(a), v);
         end
         // First pass keeps the two-wire pins at their reset place
         if (i > 0) wr(`PSC_OFS_OPT2, 8'($urandom));
         for (int a = 1; a < 10; a++) begin
            if (a != 5) rd(4'(a), (a < 5) ? regs[a] & 8'h3F : regs[a], "readback");
         end
         rd(`PSC_OFS_OPT2, regs[`PSC_OFS_OPT2] & 8'h01, "relocate");
         @(posedge clk_i);
         step <= 1'b1;
         @(posedge clk_i);
         step <= 1'b0;
         repeat (3) @(posedge clk_i);
         #1;
         for (int p = 0; p < `PSC_NPIN; p++) begin
            chk("grant", exp_grant(p), 8'(grant_o[p]));
            chk("pad", exp_pad(p), seen_pad(pad_o[p]));
            chk("pin level", 8'(pad_in[p]), 8'(pin_in_o[p]));
         end
         rd(`PSC_OFS_DATA_A, {2'b00, pad_in[5:0]}, "pins A");
         rd(`PSC_OFS_DATA_B, pad_in[13:6], "pins B");
         // Out-of-range select on the first pass must read zero
         v = (i == 0) ? 8'h0F : 8'($urandom % 16);
         wr(`PSC_OFS_OWN_SEL, v);
         rd(`PSC_OFS_OWN_STAT, exp_stat(int'(v)), "owner status");
         $display("test %0d done", i);
      end
      // ----------------------------------------------------------------
      // Reset in mid-run clears every control
      // ----------------------------------------------------------------
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      for (int k = 0; k < 16; k++) regs[k] = 8'h00;
      #1;
      for (int p = 0; p < `PSC_NPIN; p++) begin
         chk("mid reset pad", 8'h00, seen_pad(pad_o[p]));
         chk("mid reset grant", 8'h01, 8'(grant_o[p]));
      end
      rd(`PSC_OFS_OPT2, 8'h00, "mid reset relocate");
      $display("test mid reset done");
      finish_test();
   end
endmodule // testbench
